// [emr_pkg.sv]
// emr_pkg: constants for the embedded multiport ram block and its apb register file.
// assumes nothing of its surroundings; used by emr_top and the testbench.
package emr_pkg;
  // medium block geometry: 128 words of 36 bits, 4 bytes each with a parity bit
  localparam int unsigned MED_WORDS = 128;
  localparam int unsigned MED_AW = 7;
  localparam int unsigned MED_DW = 36;
  localparam int unsigned MED_BYTES = 4;
  localparam int unsigned BYTE_W = 9;
  // small block 32 x 18, large block 4K x 144 (geometry only for both blocks)
  localparam int unsigned SMALL_WORDS = 32;
  localparam int unsigned SMALL_DW = 18;
  localparam int unsigned LARGE_WORDS = 4096;
  localparam int unsigned LARGE_DW = 144;
  // narrow port view: x1 over the same storage
  localparam int unsigned BIT_AW = 12;
  // apb register offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_A_ADDR = 12'h004;
  localparam logic [11:0] OFF_A_DATA = 12'h008;
  localparam logic [11:0] OFF_B_ADDR = 12'h00c;
  localparam logic [11:0] OFF_B_DATA = 12'h010;
  localparam logic [11:0] OFF_PAR = 12'h014;
  localparam logic [11:0] OFF_STAT = 12'h018;
  // ctrl fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_OREG = 2;
  localparam int unsigned CTRL_BMODE = 3;
  localparam int unsigned CTRL_CLR_IN = 4;
  localparam int unsigned CTRL_CLR_OUT = 5;
  localparam int unsigned CTRL_BE_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h00000f00;
  typedef enum logic [1:0] {
    EMR_TRUE_DP,
    EMR_SIMPLE_DP,
    EMR_SINGLE,
    EMR_SPLIT_SP
  } emr_mode_t;
endpackage

// [emr_top.sv]
// emr_top: medium embedded ram block reached over apb.
// assumes an apb master on clk_sys_in; both ports share the single system clock.
`timescale 1ns/100ps
`default_nettype none
module emr_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // read data of both ports
  output logic [35:0] qa_out,
  output logic [35:0] qb_out
);
  logic [35:0] mem_q [emr_pkg::MED_WORDS];
  logic [31:0] ctrl_q;
  logic [11:0] a_addr_q;
  logic [11:0] b_addr_q;
  logic [3:0] par_q;
  logic [35:0] a_din_q;
  logic [35:0] b_din_q;
  logic [6:0] a_ra_q;
  logic [6:0] b_ra_q;
  logic [3:0] a_be_q;
  logic a_we_q;
  logic b_we_q;
  logic b_bit_q;
  logic [4:0] b_bsel_q;
  logic [35:0] a_raw;
  logic [35:0] b_raw;
  logic [35:0] a_oreg_q;
  logic [35:0] b_oreg_q;
  logic [35:0] qa_d;
  logic [35:0] qb_d;
  logic apb_wr;
  logic apb_rd;
  logic in_clr;
  logic out_clr;
  logic oreg_en;
  logic [6:0] a_word;
  logic [6:0] b_word;
  logic [31:0] rdata_d;
  logic map_hit;
  emr_pkg::emr_mode_t mode;
  logic [35:0] din_pk;
  logic a_wr_req;
  logic b_wr_req;
  logic ro_hit;

  assign mode = emr_pkg::emr_mode_t'(ctrl_q[emr_pkg::CTRL_MODE_LSB +: 2]);
  assign oreg_en = ctrl_q[emr_pkg::CTRL_OREG];
  assign in_clr = ctrl_q[emr_pkg::CTRL_CLR_IN];
  assign out_clr = ctrl_q[emr_pkg::CTRL_CLR_OUT];
  // apb access phase; every access completes in its first access cycle
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_rd = psel_in && penable_in && !pwrite_in;
  assign a_wr_req = apb_wr && paddr_in == emr_pkg::OFF_A_DATA;
  // port b has no write path in the simple dual-port and single-port modes
  assign b_wr_req = apb_wr && paddr_in == emr_pkg::OFF_B_DATA
                    && mode != emr_pkg::EMR_SIMPLE_DP && mode != emr_pkg::EMR_SINGLE;
  // the status word is read-only, so a write to it is refused
  assign ro_hit = pwrite_in && paddr_in == emr_pkg::OFF_STAT;
  assign din_pk = {par_q[3], pwdata_in[31:24], par_q[2], pwdata_in[23:16],
                   par_q[1], pwdata_in[15:8], par_q[0], pwdata_in[7:0]};

  // in split mode port a lives in the lower half and port b in the upper, unless the one-bit view picks its word from b_addr_q[11:5]
  always_comb begin
    a_word = a_addr_q[6:0];
    b_word = b_addr_q[6:0];
    if (mode == emr_pkg::EMR_SPLIT_SP) begin
      a_word = {1'b0, a_addr_q[5:0]};
      b_word = {1'b1, b_addr_q[5:0]};
    end
    if (ctrl_q[emr_pkg::CTRL_BMODE]) begin
      b_word = b_addr_q[11:5];
    end
  end

  // configuration registers, one process each
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= emr_pkg::CTRL_RST;
    end else if (apb_wr && paddr_in == emr_pkg::OFF_CTRL) begin
      ctrl_q <= pwdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_addr_q <= 12'h000;
    end else if (apb_wr && paddr_in == emr_pkg::OFF_A_ADDR) begin
      a_addr_q <= pwdata_in[11:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_addr_q <= 12'h000;
    end else if (apb_wr && paddr_in == emr_pkg::OFF_B_ADDR) begin
      b_addr_q <= pwdata_in[11:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_q <= 4'h0;
    end else if (apb_wr && paddr_in == emr_pkg::OFF_PAR) begin
      par_q <= pwdata_in[3:0];
    end
  end

  // port a input registers; the clear empties them at once
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_din_q <= 36'h000000000;
      a_we_q <= 1'b0;
      a_be_q <= 4'h0;
      a_ra_q <= 7'h00;
    end else if (in_clr) begin
      a_din_q <= 36'h000000000;
      a_we_q <= 1'b0;
      a_be_q <= 4'h0;
      a_ra_q <= 7'h00;
    end else begin
      // a write to a data register is one registered write request
      a_we_q <= a_wr_req;
      a_din_q <= din_pk;
      a_be_q <= ctrl_q[emr_pkg::CTRL_BE_LSB +: 4];
      a_ra_q <= a_word;
    end
  end

  // port b input registers, including the bit select of the one-bit view
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_din_q <= 36'h000000000;
      b_we_q <= 1'b0;
      b_ra_q <= 7'h00;
      b_bit_q <= 1'b0;
      b_bsel_q <= 5'h00;
    end else if (in_clr) begin
      b_din_q <= 36'h000000000;
      b_we_q <= 1'b0;
      b_ra_q <= 7'h00;
      b_bit_q <= 1'b0;
      b_bsel_q <= 5'h00;
    end else begin
      b_we_q <= b_wr_req;
      b_din_q <= din_pk;
      b_ra_q <= b_word;
      b_bit_q <= ctrl_q[emr_pkg::CTRL_BMODE];
      b_bsel_q <= b_addr_q[4:0];
    end
  end

  // contents are not reset; software loads them before use
  always_ff @(posedge clk_sys_in) begin
    if (a_we_q) begin
      for (int i = 0; i < 4; i++) begin
        if (a_be_q[i]) begin
          mem_q[a_ra_q][i*9 +: 9] <= a_din_q[i*9 +: 9];
        end
      end
    end
    // port b writes after a, so on a collision port b wins
    if (b_we_q) begin
      if (b_bit_q) begin
        mem_q[b_ra_q][b_bsel_q] <= b_din_q[0];
      end else begin
        mem_q[b_ra_q] <= b_din_q;
      end
    end
  end

  // array read reflects contents before any same-edge write
  assign a_raw = mem_q[a_ra_q];

  // the one-bit view returns the selected bit in the low position
  always_comb begin
    b_raw = mem_q[b_ra_q];
    if (b_bit_q) begin
      b_raw = {35'h000000000, mem_q[b_ra_q][b_bsel_q]};
    end
  end

  // output registers clear at once, and with oreg_en set the output path is zeroed as well
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_oreg_q <= 36'h000000000;
    end else if (out_clr) begin
      a_oreg_q <= 36'h000000000;
    end else begin
      a_oreg_q <= a_raw;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_oreg_q <= 36'h000000000;
    end else if (out_clr) begin
      b_oreg_q <= 36'h000000000;
    end else begin
      b_oreg_q <= b_raw;
    end
  end

  // bypass gives flow-through of the registered address
  always_comb begin
    qa_d = oreg_en ? a_oreg_q : a_raw;
    if (oreg_en && out_clr) begin
      qa_d = 36'h000000000;
    end
  end

  always_comb begin
    qb_d = oreg_en ? b_oreg_q : b_raw;
    if (oreg_en && out_clr) begin
      qb_d = 36'h000000000;
    end
  end

  // single outputs come from flops; this costs one cycle on both paths
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      qa_out <= 36'h000000000;
    end else begin
      qa_out <= qa_d;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      qb_out <= 36'h000000000;
    end else begin
      qb_out <= qb_d;
    end
  end

  always_comb begin
    map_hit = 1'b1;
    rdata_d = 32'h00000000;
    case (paddr_in)
      emr_pkg::OFF_CTRL: rdata_d = ctrl_q;
      emr_pkg::OFF_A_ADDR: rdata_d = {20'h00000, a_addr_q};
      emr_pkg::OFF_A_DATA: rdata_d = {qa_out[34:27], qa_out[25:18], qa_out[16:9], qa_out[7:0]};
      emr_pkg::OFF_B_ADDR: rdata_d = {20'h00000, b_addr_q};
      emr_pkg::OFF_B_DATA: rdata_d = {qb_out[34:27], qb_out[25:18], qb_out[16:9], qb_out[7:0]};
      emr_pkg::OFF_PAR: rdata_d = {24'h000000, qb_out[35], qb_out[26], qb_out[17], qb_out[8],
                                   qa_out[35], qa_out[26], qa_out[17], qa_out[8]};
      emr_pkg::OFF_STAT: rdata_d = {29'h00000000, b_we_q, a_we_q, in_clr};
      default: map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && (!map_hit || ro_hit);
      // read data is captured in the setup cycle only, so it stands until the next read
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= rdata_d;
      end
    end
  end
endmodule
`default_nettype wire

// [emr_top_assertions.sv]
// emr_chk: apb handshake and read-port checks on the emr_top ports.
// assumes the apb master holds each request until pready_out.
`timescale 1ns/100ps
`default_nettype none
module emr_chk (
  // watched ports
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [35:0] qa_out
);
  logic [2:0] age_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  // cycles since the last write; read data may only move shortly after one
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      age_q <= 3'h0;
    end else if (psel_in && penable_in && pwrite_in) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  AST_RDY_AFTER_SETUP: assert property (setup_s |=> pready_out)
    else $error("no pready in access cycle");
  AST_RDY_ONE: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  AST_RDY_IN_ACCESS: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access");
  AST_ERR_PAIR: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  AST_ERR_UNMAPPED: assert property (setup_s ##0 paddr_in > 12'h018 |=> pslverr_out)
    else $error("unmapped access not refused");
  AST_READ_OK: assert property (setup_s ##0 !pwrite_in && paddr_in <= 12'h018
    && paddr_in[1:0] == 2'h0 |=> !pslverr_out) else $error("mapped read refused");
  AST_PRDATA_HOLD: assert property ($changed(prdata_out) |-> pready_out && !pwrite_in)
    else $error("read data moved without a read");
  AST_QA_CAUSE: assert property ($changed(qa_out) |-> age_q < 3'h5)
    else $error("port a data moved without a write");
endmodule
bind emr_top emr_chk u_chk (.clk_sys_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .prdata_out, .pready_out, .pslverr_out, .qa_out);
`default_nettype wire

// [emr_fab.sv]
// emr_fab: fabric-side apb master driving the ram block registers.
// assumes the slave answers with pready; a lost answer returns an unknown error flag.
`timescale 1ns/100ps
`default_nettype none
module emr_fab (
  // apb master
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  output logic psel_out = 1'b0,
  output logic penable_out = 1'b0,
  output logic pwrite_out = 1'b0,
  output logic [11:0] paddr_out = 12'h0,
  output logic [31:0] pwdata_out = 32'h0
);
  // request held until pready is sampled; write-enable use stays with the caller
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    while (!pready_in && n < 40) begin
      n++;
      @(posedge clk_in);
    end
    q = prdata_in;
    err = (n < 40) ? pslverr_in : 1'bx;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb_embedded_multiport_ram_block.sv]
// tb: directed scenarios on emr_top through the fabric apb model.
// assumes emr_pkg, emr_chk and emr_fab are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_embedded_multiport_ram_block;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, e;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, q;
  logic [35:0] qa_out, qb_out;
  int bad_count = 0;
  int n_tests = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  emr_top DUT (.clk_sys_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .qa_out, .qb_out);
  emr_fab u_fab (.clk_in(clk_sys_in), .pready_in(pready_out), .pslverr_in(pslverr_out),
    .prdata_in(prdata_out), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in));
  // parity register is set to all ones before any data write
  function automatic logic [35:0] pk(input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      pk[9*i +: 9] = {1'b1, d[8*i +: 8]};
    end
  endfunction
  task automatic chk(input string s, input logic [35:0] x, input logic [35:0] g);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  // a lost pready ends the run at once as a mismatch
  task automatic tmo_chk();
    if (e === 1'bx) begin
      bad_count++;
      $display("ERROR pready expected 1 seen 0");
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
    u_fab.xfer(1'b1, a, d, q, e);
    tmo_chk();
    chk("pslverr", {35'h0, x}, {35'h0, e});
  endtask
  task automatic look(input int n, input logic [31:0] d);
    repeat (n) @(posedge clk_sys_in);
    #1;
    chk("qa", pk(d), qa_out);
  endtask
  task automatic t_reset();
    chk("qa", 36'h0, qa_out);
    rst_n_in <= 1'b1;
    u_fab.xfer(1'b0, emr_pkg::OFF_CTRL, 32'h0, q, e);
    tmo_chk();
    chk("ctrl", {4'h0, emr_pkg::CTRL_RST}, {4'h0, q});
  endtask
  task automatic t_write();
    wr(emr_pkg::OFF_PAR, 32'hf, 1'b0);
    wr(emr_pkg::OFF_A_ADDR, 32'h5, 1'b0);
    wr(emr_pkg::OFF_A_DATA, 32'h12345678, 1'b0);
    look(2, 32'h12345678);
  endtask
  task automatic t_oreg();
    wr(emr_pkg::OFF_CTRL, 32'hf04, 1'b0);
    wr(emr_pkg::OFF_A_DATA, 32'h0badcafe, 1'b0);
    look(2, 32'h12345678);
    look(1, 32'h0badcafe);
  endtask
  task automatic t_bytes();
    wr(emr_pkg::OFF_CTRL, 32'h304, 1'b0);
    wr(emr_pkg::OFF_A_DATA, 32'haabbccdd, 1'b0);
    look(3, 32'h0badccdd);
  endtask
  task automatic t_clear();
    wr(emr_pkg::OFF_CTRL, 32'hf24, 1'b0);
    repeat (1) @(posedge clk_sys_in);
    #1;
    chk("qa", 36'h0, qa_out);
    wr(emr_pkg::OFF_CTRL, 32'hf04, 1'b0);
    look(3, 32'h0badccdd);
  endtask
  task automatic t_ports();
    wr(emr_pkg::OFF_B_ADDR, 32'h5, 1'b0);
    wr(emr_pkg::OFF_B_DATA, 32'h5a5aa5a5, 1'b0);
    look(3, 32'h5a5aa5a5);
    chk("qb", pk(32'h5a5aa5a5), qb_out);
    wr(emr_pkg::OFF_CTRL, 32'hf05, 1'b0);
    wr(emr_pkg::OFF_B_DATA, 32'h11111111, 1'b0);
    look(3, 32'h5a5aa5a5);
    chk("qb", pk(32'h5a5aa5a5), qb_out);
    wr(12'h040, 32'h0, 1'b1);
    wr(emr_pkg::OFF_STAT, 32'h0, 1'b1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    t_reset();
    t_write();
    t_oreg();
    t_bytes();
    t_clear();
    t_ports();
    close_out();
  end
endmodule
`default_nettype wire
